// file: nemc_map.svh
// Offsets, field positions, reset values and timing counts of the memory control layer
`ifndef NEMC_MAP_SVH
`define NEMC_MAP_SVH
`define NEMC_OFF_CTRL        12'h000
`define NEMC_OFF_SPACE_CFG   12'h004
`define NEMC_OFF_STATUS      12'h008
`define NEMC_OFF_ACCESS      12'h00C
`define NEMC_CTRL_DIV_LSB    0
`define NEMC_CTRL_DIV_MSB    1
`define NEMC_CTRL_BUSREQ_BIT 2
`define NEMC_CTRL_PDT_BIT    3
`define NEMC_CTRL_RST        32'h0000_0000
`define NEMC_CFG_RST         32'h0000_0000
`define NEMC_CFG_TYPE_W      2
`define NEMC_CFG_RSEL_BIT    2
`define NEMC_CFG_STRIDE      4
`define NEMC_ACC_WR_BIT      0
`define NEMC_ACC_GO_BIT      1
`define NEMC_ACC_SPACE_LSB   26
`define NEMC_ACC_SPACE_MSB   31
`define NEMC_ACCESS_CYCLES   4'h4
`define NEMC_DIV4_HALF       3'h2
`define NEMC_DIV6_HALF       3'h3
`endif

// file: nemc_pkg.sv
// Types shared by the memory control layer
package nemc_pkg;
  typedef enum logic [1:0] {
    NEMC_MEM_ASYNC = 2'h0,
    NEMC_MEM_SDRAM = 2'h1,
    NEMC_MEM_SYNC  = 2'h2,
    NEMC_MEM_NONE  = 2'h3
  } nemc_mem_type;
  typedef enum logic [1:0] {
    NEMC_CLK_EXT  = 2'h0,
    NEMC_CLK_DIV4 = 2'h1,
    NEMC_CLK_DIV6 = 2'h2,
    NEMC_CLK_RSVD = 2'h3
  } nemc_clk_sel_type;
  typedef struct packed {
    logic read_strobe_b;
    logic output_strobe_b;
    logic write_strobe_b;
    logic fifo_oe_b;
    logic [3:0] chip_sel_b;
  } nemc_strobe_type;
endpackage

// file: nemc_clkdiv.sv
// Divider making a square clock, toggled every half system-clock cycles, from a system-clock count
`timescale 1ns/1ps
module nemc_clkdiv (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [2:0] half,
  output logic            clk_out
);
  logic [2:0] cnt_r;
  logic       clk_r;
  wire        wrap = (cnt_r == half - 3'h1);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      clk_r <= 1'b0;
    end else begin
      cnt_r <= wrap ? 3'h0 : cnt_r + 3'h1;
      clk_r <= wrap ? ~clk_r : clk_r;
    end
  end
  assign clk_out = clk_r;
endmodule

// file: nemc_ctrl.sv
// Control, clocking and arbitration layer of the narrow external memory interface
//
// Operation
// (R1) Input clock picked once at reset
// (R2) Default strap selects external input clock
// (R3) Strap 00 ext, 01 div4, 10 div6
// (R4) Divided clock out ratio 1, 2, 4
// (R5) Full rate clock out undivided
// (R6) Read strobe select picks address/read strobe
// (R7) Shared read pin follows memory type
// (R8) Shared output pin follows memory type
// (R9) Shared write pin follows memory type
// (R10) Dedicated output strobe for space three
// (R11) Async ready sampled during async access
// (R12) Hold request answered by hold acknowledge
// (R13) Bus request output shows bus need
// (R14) Peripheral direct transfer output driven
// (R15) Chip selects from bits 26-31, one only
// (R16) Finish access, release pins, then acknowledge
`timescale 1ns/1ps
`include "nemc_map.svh"
module nemc_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  input_clock_strap_select,
  input  wire logic        ext_if_clock_in,
  input  wire logic        async_ready_in,
  input  wire logic        hold_req_in,
  output logic             hold_ack_out,
  output logic             bus_request_out,
  output logic             periph_direct_xfer,
  output logic             full_rate_clock_out,
  output logic             divided_clock_out,
  output logic             shared_read_strobe,
  output logic             shared_output_strobe,
  output logic             shared_write_strobe,
  output logic             fifo_space_output_strobe,
  output logic [3:0]       chip_select_b,
  output logic             ctrl_oe_b
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // ------------------------------------------------------------
  // Clock source straps
  // ------------------------------------------------------------
  // Captured on the first clock after release; later strap motion is ignored
  logic                      strap_done_r;
  nemc_pkg::nemc_clk_sel_type clk_sel_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
      clk_sel_r    <= nemc_pkg::NEMC_CLK_EXT; // (R2)
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      clk_sel_r    <= nemc_pkg::nemc_clk_sel_type'(input_clock_strap_select); // (R1)
    end
  end

  // ------------------------------------------------------------
  // Interface clock generation
  // ------------------------------------------------------------
  logic clk_div4;
  logic clk_div6;
  nemc_clkdiv u_div4 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .half    (`NEMC_DIV4_HALF),
    .clk_out (clk_div4)
  );
  nemc_clkdiv u_div6 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .half    (`NEMC_DIV6_HALF),
    .clk_out (clk_div6)
  );
  // Reserved code falls back to the external clock
  wire if_clk = (clk_sel_r == nemc_pkg::NEMC_CLK_DIV4) ? clk_div4 :
                (clk_sel_r == nemc_pkg::NEMC_CLK_DIV6) ? clk_div6 :
                ext_if_clock_in; // (R3)

  // Edge counting on the selected clock keeps everything in one domain
  logic if_clk_q_r;
  logic [1:0] edge_cnt_r;
  logic       full_clk_r;
  logic       div_clk_r;
  logic [1:0] div_ratio;
  wire        if_rise = if_clk & ~if_clk_q_r;
  wire        if_fall = ~if_clk & if_clk_q_r;
  wire [1:0]  edge_cnt_nxt = edge_cnt_r + 2'h1;
  wire        div_toggle = (div_ratio == 2'h0) ? (if_rise | if_fall) :
                           (div_ratio == 2'h1) ? if_rise :
                           (if_rise & edge_cnt_r[0]);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      if_clk_q_r <= 1'b0;
      edge_cnt_r <= 2'h0;
      full_clk_r <= 1'b0;
      div_clk_r  <= 1'b0;
    end else begin
      if_clk_q_r <= if_clk;
      full_clk_r <= if_clk; // (R5)
      edge_cnt_r <= if_rise ? edge_cnt_nxt : edge_cnt_r;
      div_clk_r  <= div_toggle ? ~div_clk_r : div_clk_r; // (R4)
    end
  end

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] cfg_r;
  logic [5:0]  acc_space_r;
  logic        acc_wr_r;
  logic        acc_go;
  wire         apb_wr = psel & penable & pwrite;
  wire         apb_rd = psel & penable & ~pwrite;
  wire         hit_ctrl = (paddr == `NEMC_OFF_CTRL);
  wire         hit_cfg  = (paddr == `NEMC_OFF_SPACE_CFG);
  wire         hit_stat = (paddr == `NEMC_OFF_STATUS);
  wire         hit_acc  = (paddr == `NEMC_OFF_ACCESS);
  wire         hit_any  = hit_ctrl | hit_cfg | hit_stat | hit_acc;
  assign div_ratio = ctrl_r[`NEMC_CTRL_DIV_MSB:`NEMC_CTRL_DIV_LSB];

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_BUSY = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_REL  = 4'b1000
  } nemc_state_type;
  nemc_state_type state_r;
  nemc_state_type state_nxt;

  wire [31:0] status_word = {26'h0, async_ready_in, clk_sel_r, state_r == ST_HOLD,
                             state_r == ST_BUSY, hold_req_in};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_cfg  ? cfg_r :
                       hit_stat ? status_word :
                       hit_acc  ? {acc_space_r, 25'h0, acc_wr_r} : 32'h0;
  // Access start is refused while busy or held; software polls status
  assign acc_go = apb_wr & hit_acc & pwdata[`NEMC_ACC_GO_BIT] & (state_r == ST_IDLE);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r      <= `NEMC_CTRL_RST;
      cfg_r       <= `NEMC_CFG_RST;
      acc_space_r <= 6'h00;
      acc_wr_r    <= 1'b0;
      prdata      <= 32'h0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
      if (apb_wr & pready & hit_ctrl) begin
        ctrl_r <= pwdata & 32'h0000_000F;
      end
      if (apb_wr & pready & hit_cfg) begin
        cfg_r <= pwdata & 32'h0000_7777;
      end
      if (acc_go & pready) begin
        acc_space_r <= pwdata[`NEMC_ACC_SPACE_MSB:`NEMC_ACC_SPACE_LSB]; // (R15)
        acc_wr_r    <= pwdata[`NEMC_ACC_WR_BIT];
      end
    end
  end
  wire unused_rd = apb_rd;

  // ------------------------------------------------------------
  // Access and hold sequencing
  // ------------------------------------------------------------
  logic [3:0] acc_cnt_r;
  logic       hold_ack_r;
  wire        start   = acc_go & pready;
  wire [1:0]  space   = acc_space_r[1:0];
  wire [3:0]  cfg_sp  = cfg_r[{space, 2'h0} +: 4];
  wire [1:0]  mtype   = cfg_sp[`NEMC_CFG_TYPE_W-1:0];
  wire        rsel    = cfg_sp[`NEMC_CFG_RSEL_BIT];
  wire        is_async = (mtype == nemc_pkg::NEMC_MEM_ASYNC);
  wire        acc_done = (acc_cnt_r == 4'h0) & (~is_async | async_ready_in); // (R11)
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (hold_req_in) state_nxt = ST_REL;
        else if (start) state_nxt = ST_BUSY;
      end
      ST_BUSY: if (acc_done) state_nxt = hold_req_in ? ST_REL : ST_IDLE; // (R16)
      ST_REL:  state_nxt = ST_HOLD;
      ST_HOLD: if (!hold_req_in) state_nxt = ST_IDLE; // (R12)
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      acc_cnt_r  <= 4'h0;
      hold_ack_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      acc_cnt_r  <= start ? `NEMC_ACCESS_CYCLES : (acc_cnt_r != 4'h0) ? acc_cnt_r - 4'h1 :
                    acc_cnt_r;
      hold_ack_r <= (state_nxt == ST_HOLD); // (R16)
    end
  end

  // ------------------------------------------------------------
  // Strobe multiplexing
  // ------------------------------------------------------------
  wire busy = (state_r == ST_BUSY);
  wire rd   = busy & ~acc_wr_r;
  wire wr   = busy & acc_wr_r;
  nemc_pkg::nemc_strobe_type strb_nxt;
  nemc_pkg::nemc_strobe_type strb_r;
  wire sel_in_range = (acc_space_r[5:2] == 4'h0);
  // Address strobe marks the access start; read enable covers the read
  wire sync_read = rsel ? rd : (busy & (acc_cnt_r == `NEMC_ACCESS_CYCLES)); // (R6)
  wire sdram_cas = busy;
  wire sdram_ras = busy & (acc_cnt_r == `NEMC_ACCESS_CYCLES);
  always_comb begin
    strb_nxt = '{read_strobe_b: 1'b1, output_strobe_b: 1'b1, write_strobe_b: 1'b1,
                 fifo_oe_b: 1'b1, chip_sel_b: 4'hF};
    if (busy & sel_in_range) begin
      strb_nxt.chip_sel_b = ~(4'h1 << space); // (R15)
      unique case (nemc_pkg::nemc_mem_type'(mtype))
        nemc_pkg::NEMC_MEM_ASYNC: begin
          strb_nxt.read_strobe_b   = ~rd; // (R7)
          strb_nxt.output_strobe_b = ~rd; // (R8)
          strb_nxt.write_strobe_b  = ~wr; // (R9)
        end
        nemc_pkg::NEMC_MEM_SDRAM: begin
          strb_nxt.read_strobe_b   = ~sdram_cas; // (R7)
          strb_nxt.output_strobe_b = ~sdram_ras; // (R8)
          strb_nxt.write_strobe_b  = ~wr; // (R9)
        end
        nemc_pkg::NEMC_MEM_SYNC: begin
          strb_nxt.read_strobe_b   = ~sync_read; // (R7)
          strb_nxt.output_strobe_b = ~rd; // (R8)
          strb_nxt.write_strobe_b  = ~wr; // (R9)
          strb_nxt.fifo_oe_b       = ~(rd & (space == 2'h3)); // (R10)
        end
        nemc_pkg::NEMC_MEM_NONE: begin
          strb_nxt.chip_sel_b = 4'hF;
        end
      endcase
    end
  end
  logic oe_b_r;
  logic bus_req_r;
  logic pdt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strb_r    <= '{read_strobe_b: 1'b1, output_strobe_b: 1'b1, write_strobe_b: 1'b1,
                     fifo_oe_b: 1'b1, chip_sel_b: 4'hF};
      oe_b_r    <= 1'b1;
      bus_req_r <= 1'b0;
      pdt_r     <= 1'b1;
    end else begin
      strb_r    <= strb_nxt;
      oe_b_r    <= (state_nxt == ST_REL) | (state_nxt == ST_HOLD); // (R16)
      bus_req_r <= ctrl_r[`NEMC_CTRL_BUSREQ_BIT] | busy | start; // (R13)
      pdt_r     <= ~(busy & ctrl_r[`NEMC_CTRL_PDT_BIT]); // (R14)
    end
  end
  assign hold_ack_out             = hold_ack_r;
  assign bus_request_out          = bus_req_r;
  assign periph_direct_xfer       = pdt_r;
  assign full_rate_clock_out      = full_clk_r;
  assign divided_clock_out        = div_clk_r;
  assign shared_read_strobe       = strb_r.read_strobe_b;
  assign shared_output_strobe     = strb_r.output_strobe_b;
  assign shared_write_strobe      = strb_r.write_strobe_b;
  assign fifo_space_output_strobe = strb_r.fifo_oe_b;
  assign chip_select_b            = strb_r.chip_sel_b;
  assign ctrl_oe_b                = oe_b_r;
endmodule

// file: nemc_props.sv
// Port-level checker for the memory control layer
`timescale 1ns/1ps
module nemc_props (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       hold_req_in,
  input wire logic       hold_ack_out,
  input wire logic       ctrl_oe_b,
  input wire logic [3:0] chip_select_b,
  input wire logic       shared_read_strobe,
  input wire logic       shared_write_strobe,
  input wire logic       fifo_space_output_strobe
);
  // ----------------
  // Sequences
  // ----------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable;
  endsequence
  // Host has let go while the grant still stands
  sequence s_drop;
    hold_ack_out && !hold_req_in;
  endsequence
  a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
    else $error("apb answer not a one cycle pulse");
  a_one_chip_sel: assert property ($onehot0(~chip_select_b))
    else $error("more than one chip select");
  a_fifo_space_three: assert property (!fifo_space_output_strobe |-> !chip_select_b[3])
    else $error("fifo strobe outside space three");
  a_rd_wr_apart: assert property (shared_read_strobe || shared_write_strobe)
    else $error("read and write strobes together");
  a_ack_released: assert property (hold_ack_out |-> ctrl_oe_b && chip_select_b == 4'hF)
    else $error("pins driven during grant");
  a_grant_order: assert property ($rose(hold_ack_out) |-> $past(ctrl_oe_b))
    else $error("grant before release");
  a_ack_drop: assert property (s_drop |=> !hold_ack_out)
    else $error("grant kept after request");
  a_no_ack_unasked: assert property (!hold_req_in && !hold_ack_out |=> !hold_ack_out)
    else $error("grant without request");
  a_ack_wait: assert property (hold_req_in && !hold_ack_out |-> ##[1:60] hold_ack_out)
    else $error("grant too late");
endmodule
bind nemc_ctrl nemc_props u_props (.clk_sys, .rst_b, .psel, .penable, .pready, .hold_req_in,
  .hold_ack_out, .ctrl_oe_b, .chip_select_b, .shared_read_strobe, .shared_write_strobe,
  .fifo_space_output_strobe);

// file: nemc_far_model.sv
// Model of the async memory ready line and the bus-sharing host
`timescale 1ns/1ps
module nemc_far_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [3:0] slow_wait,
  input  wire logic       want_hold,
  input  wire logic [3:0] chip_select_b,
  input  wire logic       hold_ack_out,
  output logic            hold_req_in,
  output logic            async_ready_in
);
  logic [3:0] wait_r;
  // Ready line released outside an access, so the pull-up wins
  assign async_ready_in = (chip_select_b == 4'hF) || (wait_r >= slow_wait);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 4'h0;
      hold_req_in <= 1'b0;
    end else begin
      wait_r <= (chip_select_b == 4'hF) ? 4'h0 : wait_r + {3'h0, wait_r != 4'hF};
      // Request is never withdrawn before the grant was seen
      if (want_hold) begin
        hold_req_in <= 1'b1;
      end else if (hold_ack_out) begin
        hold_req_in <= 1'b0;
      end
    end
  end
endmodule

// file: nemc_ctrl_tb.sv
// Self-checking bench of the memory control layer
`timescale 1ns/1ps
`include "nemc_map.svh"
module nemc_ctrl_tb;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} nemc_row_type;
  typedef struct packed {logic [5:0] sp; logic wr; logic [8:0] q; logic [3:0] nrd;} nemc_acc_type;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_r;
  logic pready, pslverr, err_r, hold_req_in, hold_ack_out, bus_request_out, periph_direct_xfer;
  logic full_rate_clock_out, divided_clock_out, shared_read_strobe, shared_output_strobe;
  logic shared_write_strobe, fifo_space_output_strobe, ctrl_oe_b, async_ready_in;
  logic [1:0] input_clock_strap_select = 2'h0;
  logic ext_if_clock_in = 1'b0;
  logic want_hold = 1'b0;
  logic [3:0] chip_select_b;
  logic [3:0] slow = 4'h0;
  logic [8:0] seen;
  logic pf, pd;
  int fails = 0;
  int compares = 0;
  int nrd, ncs, nf, nd, n;
  int fr[3] = '{8, 12, 8};
  int dr[3] = '{8, 6, 2};
  nemc_row_type rows[3] = '{'{`NEMC_OFF_CTRL, 32'h0000_0004, 1'b0},
    '{`NEMC_OFF_SPACE_CFG, 32'h0000_6210, 1'b0}, '{12'h010, 32'h0000_00FF, 1'b1}};
  nemc_acc_type accs[6] = '{'{6'h00, 1'b0, 9'h039, 4'h0}, '{6'h00, 1'b1, 9'h025, 4'h0},
    '{6'h01, 1'b0, 9'h059, 4'h0}, '{6'h02, 1'b0, 9'h099, 4'h1},
    '{6'h03, 1'b0, 9'h11B, 4'h5}, '{6'h03, 1'b1, 9'h105, 4'h0}};
  always #20 clk_sys = ~clk_sys;
  // External clock off the sampling edge, six system cycles a period
  always #120 ext_if_clock_in = ~ext_if_clock_in;
  nemc_ctrl dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .input_clock_strap_select, .ext_if_clock_in, .async_ready_in, .hold_req_in,
    .hold_ack_out, .bus_request_out, .periph_direct_xfer, .full_rate_clock_out,
    .divided_clock_out, .shared_read_strobe, .shared_output_strobe, .shared_write_strobe,
    .fifo_space_output_strobe, .chip_select_b, .ctrl_oe_b);
  nemc_far_model u_far (.clk_sys, .rst_b, .slow_wait(slow), .want_hold, .chip_select_b,
    .hold_ack_out, .hold_req_in, .async_ready_in);
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd_r = prdata;
    err_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] s);
    rst_b <= 1'b0;
    input_clock_strap_select <= s;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic access(input logic [5:0] sp, input logic wr);
    seen = 9'h0;
    nrd = 0;
    ncs = 0;
    apb(1'b1, `NEMC_OFF_ACCESS, {sp, 24'h0, 1'b1, wr});
    repeat (30) begin
      @(posedge clk_sys);
      seen = seen | ~{chip_select_b, shared_read_strobe, shared_output_strobe,
        shared_write_strobe, fifo_space_output_strobe, periph_direct_xfer};
      nrd += !shared_read_strobe;
      ncs += (chip_select_b != 4'hF);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 6000);
    fails++;
    complete_run();
  end
  initial begin
    do_reset(2'h0);
    // Sampled at the first live edge: pins still show their reset values, released
    chk({chip_select_b, hold_ack_out, bus_request_out, periph_direct_xfer, ctrl_oe_b}, 8'hF3);
    apb(1'b0, `NEMC_OFF_CTRL, 32'h0);
    chk(rd_r, `NEMC_CTRL_RST);
    apb(1'b0, `NEMC_OFF_SPACE_CFG, 32'h0);
    chk(rd_r, `NEMC_CFG_RST);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(err_r, rows[i].e);
      if (!rows[i].e) chk(rd_r, rows[i].d);
    end
    chk(bus_request_out, 1'b1);
    apb(1'b1, `NEMC_OFF_CTRL, 32'h0000_0008);
    foreach (accs[i]) begin
      access(accs[i].sp, accs[i].wr);
      chk(seen, accs[i].q);
      if (accs[i].nrd != 4'h0) chk(nrd, accs[i].nrd);
    end
    $display("access table done");
    slow <= 4'h8;
    access(6'h00, 1'b1);
    chk(ncs > 8, 1'b1);
    apb(1'b1, `NEMC_OFF_ACCESS, {6'h00, 24'h0, 2'h3});
    want_hold <= 1'b1;
    n = 0;
    while (hold_ack_out !== 1'b1 && n < 80) begin
      @(posedge clk_sys);
      n++;
    end
    chk({hold_ack_out, ctrl_oe_b, chip_select_b}, 6'h3F);
    want_hold <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({hold_ack_out, ctrl_oe_b}, 2'h0);
    $display("hold test done");
    for (int i = 0; i < 3; i++) begin
      do_reset(i[1:0]);
      input_clock_strap_select <= 2'h3;
      apb(1'b1, `NEMC_OFF_CTRL, i);
      apb(1'b0, `NEMC_OFF_STATUS, 32'h0);
      chk(rd_r[4:3], i[1:0]);
      repeat (24) @(posedge clk_sys);
      nf = 0;
      nd = 0;
      pf = full_rate_clock_out;
      pd = divided_clock_out;
      repeat (48) begin
        @(posedge clk_sys);
        nf += full_rate_clock_out & !pf;
        nd += divided_clock_out & !pd;
        pf = full_rate_clock_out;
        pd = divided_clock_out;
      end
      chk(nf, fr[i]);
      chk(nd, dr[i]);
    end
    $display("clock test done");
    complete_run();
  end
endmodule
